// ### src/etsl_core.sv
// Exposure trigger sequencer, fire strobes and acquisition events
//
// Contract
// RULE_01 - Internal mode times exposures from programmed settings alone.
// RULE_02 - External mode takes triggers from the trigger pin.
// RULE_03 - Software mode acts like external, trigger from host command.
// RULE_04 - External start waits one trigger, then runs as internal.
// RULE_05 - External exposure: pin level sets exposure and cycle time.
// RULE_06 - Auxiliary output selects first, last, all or any row strobe.
// RULE_07 - After reset auxiliary output carries all-rows strobe.
// RULE_08 - Each TTL input and output polarity is invertible independently.
// RULE_09 - First row read out is row 1, last is row n.
// RULE_10 - First-row strobe: row 1 exposing (rolling), all rows (global).
// RULE_11 - Last-row strobe: row n exposing; global equals first-row strobe.
// RULE_12 - All-rows strobe when every row exposes; global equals first.
// RULE_13 - Any-row strobe when some row exposes; global equals first.
// RULE_14 - Strobes high while condition holds, absent inversion.
// RULE_15 - Strobes may stay idle when their condition never occurs.
// RULE_16 - First-row strobe always on its own dedicated output.
// RULE_17 - Each event type has its own enable; only enabled reported.
// RULE_18 - Begin event when row 1 (or all rows) start exposing.
// RULE_19 - Finish event when row 1 (or all rows) stop, before readout ends.
// RULE_20 - Last-row begin and finish events for row n.
// RULE_21 - Buffer overflow stops acquisition and raises an event.
// RULE_22 - Undeliverable enabled event raises a lost-notification event.
// RULE_23 - Trigger pulses of two clocks or longer are recognised.
// RULE_24 - Ready output in external/software modes; triggers ignored otherwise.
// RULE_25 - Rolling: each row starts one row time after the previous.
// RULE_26 - Trigger pin synchronised before edge detection.
`timescale 1ns/1ps
`default_nettype none
module etsl_core
(
  // Clock, reset, enable
  input  wire logic        clock_i,
  input  wire logic        reset_i,
  input  wire logic        clk_en_i,
  // Configuration
  input  wire logic [2:0]  trig_mode_i,
  input  wire logic        global_shutter_mode_i,
  input  wire logic [1:0]  aux_sel_i,
  input  wire logic        aux_sel_load_i,
  input  wire logic        trig_in_invert_i,
  input  wire logic        fire_out_invert_i,
  input  wire logic        aux_out_invert_i,
  input  wire logic        ready_out_invert_i,
  input  wire logic [31:0] exposure_rows_i,
  input  wire logic [31:0] cycle_rows_i,
  input  wire logic [15:0] frame_rows_i,
  input  wire logic [31:0] row_clocks_i,
  input  wire logic [5:0]  event_enable_i,
  // Acquisition control
  input  wire logic        acq_start_i,
  input  wire logic        acq_stop_i,
  input  wire logic        soft_trigger_i,
  input  wire logic        ext_trigger_i,
  input  wire logic        store_overrun_i,
  input  wire logic        event_ready_i,
  // TTL outputs
  output logic             fire_o,
  output logic             aux_out_o,
  output logic             trigger_ready_o,
  // Status and events
  output logic             acquiring_o,
  output logic [5:0]       event_o,
  output logic             event_valid_o
);

  etsl_pkg::etsl_state_e state_q;
  logic [31:0] row_tick_q;
  logic        row_strobe;
  logic [31:0] expo_cnt_q;
  logic [31:0] cycle_cnt_q;
  logic [15:0] begin_row_q;
  logic [15:0] end_row_q;
  logic        ending_q;
  logic        armed_q;
  logic        ext_level;
  logic        ext_lvl_q;
  logic        ext_rise;
  logic        ext_fall;
  logic        trig_evt;
  logic [1:0]  aux_sel_q;
  logic        first_exp;
  logic        last_exp;
  logic        all_exp;
  logic        any_exp;
  logic        first_q;
  logic        last_q;
  logic        aux_pick;
  logic [5:0]  evt_raw;
  logic [5:0]  evt_pend_q;
  logic        is_int;
  logic        is_ext_expo;

  // Pin polarity applied before the synchroniser
  etsl_sync u_trig_sync
  (
    .clock_i  (clock_i),
    .reset_i  (reset_i),
    .enable_i (clk_en_i),
    .async_i  (ext_trigger_i ^ trig_in_invert_i), // RULE_08
    .level_o  (ext_level)                         // RULE_26
  );

  always_ff @(posedge clock_i)
  begin
    if (reset_i)
      ext_lvl_q <= 1'b0;
    else if (clk_en_i)
      ext_lvl_q <= ext_level;
  end

  // Two agreeing stages let a two-clock pulse through
  assign ext_rise = ext_level & ~ext_lvl_q; // RULE_23
  assign ext_fall = ~ext_level & ext_lvl_q;

  assign is_ext_expo = (trig_mode_i == etsl_pkg::ETSL_TRIG_EXT_EXPO);
  assign is_int      = (trig_mode_i == etsl_pkg::ETSL_TRIG_INTERNAL);

  always_comb
  begin
    case (trig_mode_i)
      etsl_pkg::ETSL_TRIG_EXTERNAL,
      etsl_pkg::ETSL_TRIG_EXT_START,
      etsl_pkg::ETSL_TRIG_EXT_EXPO: trig_evt = ext_rise;       // RULE_02
      etsl_pkg::ETSL_TRIG_SOFTWARE: trig_evt = soft_trigger_i; // RULE_03
      default:                      trig_evt = 1'b0;
    endcase
  end

  // Row timebase restarts on each trigger; idle and wait share state bit 1
  assign row_strobe = (row_tick_q + 32'h0000_0001 >= row_clocks_i);

  always_ff @(posedge clock_i)
  begin
    if (reset_i)
      row_tick_q <= etsl_pkg::CNT_ZERO;
    else if (clk_en_i)
      row_tick_q <= (row_strobe || !state_q[1]) ? etsl_pkg::CNT_ZERO : row_tick_q + 32'h0000_0001;
  end

  // Sequencer
  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      state_q     <= etsl_pkg::ETSL_ST_IDLE;
      expo_cnt_q  <= etsl_pkg::CNT_ZERO;
      cycle_cnt_q <= etsl_pkg::CNT_ZERO;
      armed_q     <= 1'b0;
    end
    else if (clk_en_i)
    begin
      if (acq_stop_i || store_overrun_i)
        state_q <= etsl_pkg::ETSL_ST_IDLE; // RULE_21
      else
      begin
        case (state_q)
          etsl_pkg::ETSL_ST_IDLE:
          begin
            armed_q <= 1'b0;
            if (acq_start_i)
              state_q <= is_int ? etsl_pkg::ETSL_ST_EXPOSE : etsl_pkg::ETSL_ST_WAIT; // RULE_01
            expo_cnt_q  <= etsl_pkg::CNT_ZERO;
            cycle_cnt_q <= etsl_pkg::CNT_ZERO;
          end
          etsl_pkg::ETSL_ST_WAIT:
          begin
            if (trig_evt && (trigger_ready_o ^ ready_out_invert_i)) // RULE_24
            begin
              state_q     <= etsl_pkg::ETSL_ST_EXPOSE;
              expo_cnt_q  <= etsl_pkg::CNT_ZERO;
              cycle_cnt_q <= etsl_pkg::CNT_ZERO;
              // External start runs free after its single trigger
              if (trig_mode_i == etsl_pkg::ETSL_TRIG_EXT_START)
                armed_q <= 1'b1; // RULE_04
            end
          end
          etsl_pkg::ETSL_ST_EXPOSE:
          begin
            if (row_strobe)
            begin
              expo_cnt_q  <= expo_cnt_q + 32'h0000_0001;
              cycle_cnt_q <= cycle_cnt_q + 32'h0000_0001;
            end
            // External exposure ends on the falling trigger level
            if (is_ext_expo ? ext_fall : (row_strobe && expo_cnt_q + 32'h0000_0001 >= exposure_rows_i)) // RULE_05
              state_q <= etsl_pkg::ETSL_ST_DRAIN;
          end
          etsl_pkg::ETSL_ST_DRAIN:
          begin
            if (row_strobe)
              cycle_cnt_q <= cycle_cnt_q + 32'h0000_0001;
            if (row_strobe && !ending_q && end_row_q != 16'h0000)
              state_q <= etsl_pkg::ETSL_ST_GAP;
          end
          etsl_pkg::ETSL_ST_GAP:
          begin
            if (row_strobe)
              cycle_cnt_q <= cycle_cnt_q + 32'h0000_0001;
            if (is_int || armed_q)
            begin
              if (row_strobe && cycle_cnt_q + 32'h0000_0001 >= cycle_rows_i)
              begin
                state_q     <= etsl_pkg::ETSL_ST_EXPOSE; // RULE_01
                expo_cnt_q  <= etsl_pkg::CNT_ZERO;
                cycle_cnt_q <= etsl_pkg::CNT_ZERO;
              end
            end
            else
              state_q <= etsl_pkg::ETSL_ST_WAIT; // RULE_05
          end
          default: state_q <= etsl_pkg::ETSL_ST_IDLE;
        endcase
      end
    end
  end

  // Row begin/end pointers: rows start one row time apart
  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      begin_row_q <= 16'h0000;
      end_row_q   <= 16'h0000;
      ending_q    <= 1'b0;
    end
    else if (clk_en_i)
    begin
      if (state_q == etsl_pkg::ETSL_ST_IDLE || state_q == etsl_pkg::ETSL_ST_WAIT
          || state_q == etsl_pkg::ETSL_ST_GAP)
      begin
        begin_row_q <= 16'h0000;
        end_row_q   <= 16'h0000;
        ending_q    <= 1'b0;
      end
      else
      begin
        if (state_q == etsl_pkg::ETSL_ST_EXPOSE && begin_row_q == 16'h0000 && row_strobe)
          begin_row_q <= etsl_pkg::ROW_ONE; // RULE_09
        else if (row_strobe && begin_row_q != 16'h0000 && begin_row_q < frame_rows_i)
          begin_row_q <= begin_row_q + etsl_pkg::ROW_ONE; // RULE_25
        if (row_strobe && state_q == etsl_pkg::ETSL_ST_DRAIN && !ending_q
            && end_row_q == 16'h0000)
        begin
          end_row_q <= etsl_pkg::ROW_ONE;
          ending_q  <= (frame_rows_i > etsl_pkg::ROW_ONE);
        end
        else if (row_strobe && ending_q)
        begin
          end_row_q <= end_row_q + etsl_pkg::ROW_ONE; // RULE_25
          if (end_row_q + etsl_pkg::ROW_ONE >= frame_rows_i)
            ending_q <= 1'b0;
        end
      end
    end
  end

  // Row k exposes while begun and not yet ended
  always_comb
  begin
    first_exp = (begin_row_q != 16'h0000) && (end_row_q == 16'h0000);           // RULE_10
    last_exp  = (begin_row_q == frame_rows_i) && (end_row_q < frame_rows_i)
                && (begin_row_q != 16'h0000);                                   // RULE_11
    all_exp   = first_exp && (begin_row_q == frame_rows_i);                     // RULE_12
    any_exp   = (begin_row_q != 16'h0000) && (end_row_q < frame_rows_i);        // RULE_13
    if (global_shutter_mode_i)
    begin
      // Global: every strobe follows the all-rows window
      first_exp = (state_q == etsl_pkg::ETSL_ST_EXPOSE);
      last_exp  = first_exp; // RULE_11
      all_exp   = first_exp; // RULE_12
      any_exp   = first_exp; // RULE_13
    end
  end

  // Aux source select register, defaults to all rows
  always_ff @(posedge clock_i)
  begin
    if (reset_i)
      aux_sel_q <= etsl_pkg::AUX_SEL_RESET; // RULE_07
    else if (clk_en_i && aux_sel_load_i)
      aux_sel_q <= aux_sel_i;
  end

  always_comb
  begin
    case (aux_sel_q)
      etsl_pkg::ETSL_AUX_FIRST: aux_pick = first_exp; // RULE_06
      etsl_pkg::ETSL_AUX_LAST:  aux_pick = last_exp;
      etsl_pkg::ETSL_AUX_ALL:   aux_pick = all_exp;   // RULE_15
      etsl_pkg::ETSL_AUX_ANY:   aux_pick = any_exp;
      default:                  aux_pick = all_exp;
    endcase
  end

  // Registered TTL outputs, active high unless inverted
  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      fire_o          <= 1'b0;
      aux_out_o       <= 1'b0;
      trigger_ready_o <= 1'b0;
      acquiring_o     <= 1'b0;
    end
    else if (clk_en_i)
    begin
      fire_o          <= first_exp ^ fire_out_invert_i; // RULE_16 RULE_14 RULE_08
      aux_out_o       <= aux_pick ^ aux_out_invert_i;   // RULE_14 RULE_08
      trigger_ready_o <= (state_q == etsl_pkg::ETSL_ST_WAIT && !is_int) ^ ready_out_invert_i; // RULE_24
      acquiring_o     <= (state_q != etsl_pkg::ETSL_ST_IDLE);
    end
  end

  // Edge detection for events
  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      first_q <= 1'b0;
      last_q  <= 1'b0;
    end
    else if (clk_en_i)
    begin
      first_q <= first_exp;
      last_q  <= last_exp;
    end
  end

  always_comb
  begin
    evt_raw = 6'h00;
    evt_raw[etsl_pkg::EV_FIRST_BEGIN]  = first_exp & ~first_q;  // RULE_18
    evt_raw[etsl_pkg::EV_FIRST_FINISH] = ~first_exp & first_q;  // RULE_19
    evt_raw[etsl_pkg::EV_LAST_BEGIN]   = last_exp & ~last_q;    // RULE_20
    evt_raw[etsl_pkg::EV_LAST_FINISH]  = ~last_exp & last_q;    // RULE_20
    evt_raw[etsl_pkg::EV_OVERRUN]      = store_overrun_i && (state_q != etsl_pkg::ETSL_ST_IDLE); // RULE_21
    evt_raw = evt_raw & event_enable_i; // RULE_17
  end

  // Pending events: new events win over delivery clear
  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      evt_pend_q    <= 6'h00;
      event_o       <= 6'h00;
      event_valid_o <= 1'b0;
    end
    else if (clk_en_i)
    begin
      event_valid_o <= 1'b0;
      if (event_ready_i && evt_pend_q != 6'h00)
      begin
        event_o       <= evt_pend_q;
        event_valid_o <= 1'b1;
        evt_pend_q    <= evt_raw;
      end
      else
      begin
        evt_pend_q <= evt_pend_q | evt_raw;
        // Same event again before delivery means one was lost
        if ((evt_pend_q & evt_raw & 6'h1F) != 6'h00 && event_enable_i[etsl_pkg::EV_LOST])
          evt_pend_q[etsl_pkg::EV_LOST] <= 1'b1; // RULE_22
      end
    end
  end
endmodule : etsl_core
`default_nettype wire

// ### src/etsl_pkg.sv
// Package with constants and types for the exposure trigger and strobe logic
package etsl_pkg;

  // Trigger modes
  typedef enum logic [2:0] {
    ETSL_TRIG_INTERNAL  = 3'h0,
    ETSL_TRIG_EXTERNAL  = 3'h1,
    ETSL_TRIG_SOFTWARE  = 3'h2,
    ETSL_TRIG_EXT_START = 3'h3,
    ETSL_TRIG_EXT_EXPO  = 3'h4
  } etsl_trig_e;

  // Auxiliary output source select
  typedef enum logic [1:0] {
    ETSL_AUX_FIRST = 2'h0,
    ETSL_AUX_LAST  = 2'h1,
    ETSL_AUX_ALL   = 2'h2,
    ETSL_AUX_ANY   = 2'h3
  } etsl_aux_e;

  // Sequencer states, Gray coded along idle-wait-expose-readout
  typedef enum logic [2:0] {
    ETSL_ST_IDLE    = 3'b000,
    ETSL_ST_WAIT    = 3'b001,
    ETSL_ST_EXPOSE  = 3'b011,
    ETSL_ST_DRAIN   = 3'b010,
    ETSL_ST_GAP     = 3'b110
  } etsl_state_e;

  localparam int unsigned CNT_W          = 32;
  localparam int unsigned ROW_W          = 16;
  localparam int unsigned EVT_N          = 6;
  localparam int unsigned SYNC_STAGES    = 3;
  localparam int unsigned TRIG_MIN_CLK   = 2;
  localparam logic [1:0]  AUX_SEL_RESET  = 2'h2;
  localparam logic [31:0] CNT_ZERO       = 32'h0000_0000;
  localparam logic [15:0] ROW_ONE        = 16'h0001;

  // Event bit positions
  localparam int unsigned EV_FIRST_BEGIN  = 0;
  localparam int unsigned EV_FIRST_FINISH = 1;
  localparam int unsigned EV_LAST_BEGIN   = 2;
  localparam int unsigned EV_LAST_FINISH  = 3;
  localparam int unsigned EV_OVERRUN      = 4;
  localparam int unsigned EV_LOST         = 5;

endpackage : etsl_pkg

// ### src/etsl_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module etsl_sync
(
  // Clock and reset
  input  wire logic clock_i,
  input  wire logic reset_i,
  input  wire logic enable_i,
  // Data
  input  wire logic async_i,
  output logic      level_o
);
  logic [2:0] stage_q;

  always_ff @(posedge clock_i)
  begin
    if (reset_i)
      stage_q <= 3'h0;
    else if (enable_i)
      stage_q <= {stage_q[1:0], async_i};
  end

  // Stage 0 only feeds stage 1; change accepted once stages 1 and 2 agree
  always_ff @(posedge clock_i)
  begin
    if (reset_i)
      level_o <= 1'b0;
    else if (enable_i && (stage_q[1] == stage_q[2]))
      level_o <= stage_q[2];
  end
endmodule : etsl_sync
`default_nettype wire

// ### testbench/etsl_core_chk.sv
// Assertion checker for the exposure trigger core
`timescale 1ns/1ps
`default_nettype none
module etsl_core_chk
(
  // Clock and reset
  input wire logic       clock_i,
  input wire logic       reset_i,
  input wire logic       clk_en_i,
  // Configuration
  input wire logic       global_shutter_mode_i,
  input wire logic       fire_out_invert_i,
  input wire logic       aux_out_invert_i,
  input wire logic [5:0] event_enable_i,
  // Control
  input wire logic       acq_start_i,
  input wire logic       store_overrun_i,
  input wire logic       event_ready_i,
  // Outputs
  input wire logic       fire_o,
  input wire logic       aux_out_o,
  input wire logic       acquiring_o,
  input wire logic [5:0] event_o,
  input wire logic       event_valid_o
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (reset_i || !clk_en_i);

  a_reset_quiet: assert property (disable iff (1'b0)
    reset_i |=> !acquiring_o && !event_valid_o) else $error("outputs active after reset");
  a_valid_pulse: assert property (event_valid_o |=> !event_valid_o)
    else $error("event valid longer than one cycle");
  a_enabled_only: assert property (event_valid_o |-> (event_o & ~event_enable_i) == 6'h00)
    else $error("disabled event reported");
  a_valid_ready: assert property (event_valid_o |-> $past(event_ready_i))
    else $error("event delivered while host not ready");
  a_idle_quiet: assert property (
    !acquiring_o && $past(!acquiring_o) && $past(!acquiring_o, 2) && !fire_out_invert_i
    && !$past(fire_out_invert_i) |-> !fire_o) else $error("strobe high while idle");
  a_global_aux: assert property (
    global_shutter_mode_i && $past(global_shutter_mode_i) && $past(global_shutter_mode_i, 2)
    && !fire_out_invert_i && !aux_out_invert_i |-> aux_out_o == fire_o)
    else $error("global aux differs from first-row strobe");
  a_start_acq: assert property (acq_start_i && !store_overrun_i |-> ##[1:3] acquiring_o)
    else $error("start not taken");
  a_overrun_stop: assert property (store_overrun_i && acquiring_o |-> ##[1:3] !acquiring_o)
    else $error("overrun did not stop acquisition");
  a_overrun_event: assert property (
    store_overrun_i && acquiring_o && event_enable_i[4] && event_ready_i
    |-> ##[1:4] (event_valid_o && event_o[4])) else $error("overrun event missing");
endmodule // etsl_core_chk

bind etsl_core etsl_core_chk u_chk
(
  .clock_i(clock_i),
  .reset_i(reset_i),
  .clk_en_i(clk_en_i),
  .global_shutter_mode_i(global_shutter_mode_i),
  .fire_out_invert_i(fire_out_invert_i),
  .aux_out_invert_i(aux_out_invert_i),
  .event_enable_i(event_enable_i),
  .acq_start_i(acq_start_i),
  .store_overrun_i(store_overrun_i),
  .event_ready_i(event_ready_i),
  .fire_o(fire_o),
  .aux_out_o(aux_out_o),
  .acquiring_o(acquiring_o),
  .event_o(event_o),
  .event_valid_o(event_valid_o)
);
`default_nettype wire

// ### testbench/etsl_trig_src.sv
// External trigger source model driving the trigger pin
`timescale 1ns/1ps
`default_nettype none
module etsl_trig_src
(
  // Clock
  input  wire logic       clock_i,
  // Request
  input  wire logic       go_i,
  input  wire logic [7:0] width_i,
  // Pin
  output logic            trig_o
);
  logic [7:0] left_q;
  initial left_q = 8'h00;
  initial trig_o = 1'b0;
  always @(posedge clock_i)
  begin
    if (go_i)
      left_q <= width_i;
    else if (left_q != 8'h00)
      left_q <= left_q - 8'h01;
  end
  // Skewed off the clock so the pin is truly asynchronous
  always @(left_q)
  begin
    trig_o <= #1.3 (left_q != 8'h00);
  end
endmodule // etsl_trig_src
`default_nettype wire

// ### testbench/etsl_core_tb.sv
// Self-checking bench for the exposure trigger core
`timescale 1ns/1ps
`default_nettype none
module etsl_core_tb;
  localparam int E = 6;
  localparam int N = 3;
  localparam int R = 2;
  logic        clock_i, reset_i, clk_en_i, global_shutter_mode_i, aux_sel_load_i;
  logic        trig_in_invert_i, fire_out_invert_i, aux_out_invert_i, ready_out_invert_i;
  logic [2:0]  trig_mode_i;
  logic [1:0]  aux_sel_i;
  logic [31:0] exposure_rows_i, cycle_rows_i, row_clocks_i;
  logic [15:0] frame_rows_i;
  logic [5:0]  event_enable_i, event_o, ev_seen;
  logic        acq_start_i, acq_stop_i, soft_trigger_i, ext_trigger_i, store_overrun_i;
  logic        event_ready_i, fire_o, aux_out_o, trigger_ready_o, acquiring_o, event_valid_o;
  logic        go;
  logic [7:0]  width;
  int          err_total = 0;
  int          compares = 0;
  int          fw, ao, aw, c;

  etsl_core DUT (.clock_i(clock_i), .reset_i(reset_i), .clk_en_i(clk_en_i),
    .trig_mode_i(trig_mode_i), .global_shutter_mode_i(global_shutter_mode_i),
    .aux_sel_i(aux_sel_i), .aux_sel_load_i(aux_sel_load_i),
    .trig_in_invert_i(trig_in_invert_i), .fire_out_invert_i(fire_out_invert_i),
    .aux_out_invert_i(aux_out_invert_i), .ready_out_invert_i(ready_out_invert_i),
    .exposure_rows_i(exposure_rows_i), .cycle_rows_i(cycle_rows_i),
    .frame_rows_i(frame_rows_i), .row_clocks_i(row_clocks_i),
    .event_enable_i(event_enable_i), .acq_start_i(acq_start_i), .acq_stop_i(acq_stop_i),
    .soft_trigger_i(soft_trigger_i), .ext_trigger_i(ext_trigger_i),
    .store_overrun_i(store_overrun_i), .event_ready_i(event_ready_i), .fire_o(fire_o),
    .aux_out_o(aux_out_o), .trigger_ready_o(trigger_ready_o), .acquiring_o(acquiring_o),
    .event_o(event_o), .event_valid_o(event_valid_o));
  etsl_trig_src u_src (.clock_i(clock_i), .go_i(go), .width_i(width), .trig_o(ext_trigger_i));

  initial
  begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end
  always @(negedge clock_i)
    if (event_valid_o === 1'b1) ev_seen |= event_o;

  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic start(logic [2:0] m);
    @(posedge clock_i);
    trig_mode_i <= m;
    acq_start_i <= 1'b1;
    ev_seen = 6'h00;
    @(posedge clock_i);
    acq_start_i <= 1'b0;
  endtask
  task automatic stop();
    @(posedge clock_i);
    acq_stop_i <= 1'b1;
    @(posedge clock_i);
    acq_stop_i <= 1'b0;
    repeat (6) @(posedge clock_i);
  endtask
  task automatic ext_pulse(logic [7:0] w);
    @(posedge clock_i);
    go <= 1'b1;
    width <= w;
    @(posedge clock_i);
    go <= 1'b0;
  endtask
  // Bounded waits, sampled mid-cycle to stay clear of edge updates
  task automatic wait_fire(int lim, output int n);
    n = 0;
    @(negedge clock_i);
    while (fire_o !== 1'b1 && n < lim)
    begin
      @(negedge clock_i);
      n++;
    end
  endtask
  task automatic wait_rdy();
    int n;
    n = 0;
    @(negedge clock_i);
    while (trigger_ready_o !== 1'b1 && n < 12)
    begin
      @(negedge clock_i);
      n++;
    end
    check("ready", trigger_ready_o, 1);
  endtask
  task automatic load_aux(logic [1:0] s);
    @(posedge clock_i);
    aux_sel_i <= s;
    aux_sel_load_i <= 1'b1;
    @(posedge clock_i);
    aux_sel_load_i <= 1'b0;
  endtask
  task automatic meas();
    fw = 0;
    ao = -1;
    aw = 0;
    start(3'h0);
    wait_fire(6, c);
    check("int fire", fire_o, 1);
    for (int k = 0; k < 40; k++)
    begin
      if (fire_o === 1'b1) fw++;
      if (aux_out_o === 1'b1)
      begin
        aw++;
        if (ao < 0) ao = k;
      end
      @(negedge clock_i);
    end
    check("fire width", fw, E * R);
    stop();
  endtask

  task automatic t_rolling();
    meas();
    check("aux default width", aw, (E - N + 1) * R);
    check("events", ev_seen, 6'h0f);
    event_enable_i <= 6'h03;
    for (int s = 0; s < 4; s++)
    begin
      load_aux(s[1:0]);
      meas();
      check("aux offset", ao, (s == 1 || s == 2) ? (N - 1) * R : 0);
      check("aux width", aw, s == 2 ? (E - N + 1) * R : s == 3 ? (E + N - 1) * R : E * R);
      check("enabled events", ev_seen, 6'h03);
    end
  endtask
  task automatic t_triggers();
    trig_mode_i <= 3'h1;
    ext_pulse(8'h02);
    wait_fire(12, c);
    check("idle trigger", acquiring_o, 0);
    start(3'h1);
    wait_rdy();
    ext_pulse(8'h02);
    wait_fire(14, c);
    check("ext fire", fire_o, 1);
    check("sync lag", c >= 2, 1);
    stop();
    start(3'h2);
    wait_rdy();
    @(posedge clock_i);
    soft_trigger_i <= 1'b1;
    @(posedge clock_i);
    soft_trigger_i <= 1'b0;
    wait_fire(8, c);
    check("soft fire", fire_o, 1);
    stop();
    start(3'h3);
    wait_fire(20, c);
    check("ext start wait", fire_o, 0);
    ext_pulse(8'h02);
    wait_fire(14, c);
    check("ext start fire", fire_o, 1);
    stop();
    start(3'h4);
    ext_pulse(8'h0a);
    wait_fire(14, c);
    fw = 0;
    for (int k = 0; k < 30; k++)
    begin
      if (fire_o === 1'b1) fw++;
      @(negedge clock_i);
    end
    check("ext exposure width", fw, 10);
    stop();
  endtask
  task automatic t_global_overrun();
    global_shutter_mode_i <= 1'b1;
    for (int s = 0; s < 4; s++)
    begin
      load_aux(s[1:0]);
      start(3'h0);
      wait_fire(6, c);
      check("global aux", aux_out_o, 1);
      stop();
    end
    global_shutter_mode_i <= 1'b0;
    event_enable_i <= 6'h10;
    start(3'h0);
    repeat (3) @(posedge clock_i);
    store_overrun_i <= 1'b1;
    @(posedge clock_i);
    store_overrun_i <= 1'b0;
    repeat (5) @(posedge clock_i);
    check("overrun stop", acquiring_o, 0);
    check("overrun event", ev_seen, 6'h10);
    fire_out_invert_i <= 1'b1;
    repeat (3) @(negedge clock_i);
    check("fire inverted", fire_o, 1);
    @(posedge clock_i);
    clk_en_i <= 1'b0;
    aux_out_invert_i <= 1'b1;
    repeat (3) @(negedge clock_i);
    check("frozen aux", aux_out_o, 0);
    @(posedge clock_i);
    clk_en_i <= 1'b1;
    repeat (3) @(negedge clock_i);
    check("aux inverted", aux_out_o, 1);
    @(posedge clock_i);
    fire_out_invert_i <= 1'b0;
    aux_out_invert_i <= 1'b0;
    repeat (3) @(negedge clock_i);
    check("fire restored", fire_o, 0);
  endtask

  initial
  begin
    {clk_en_i, event_ready_i, reset_i} = 3'b111;
    {global_shutter_mode_i, aux_sel_load_i, trig_in_invert_i, fire_out_invert_i} = 4'h0;
    {aux_out_invert_i, ready_out_invert_i, acq_start_i, acq_stop_i} = 4'h0;
    {soft_trigger_i, store_overrun_i, go} = 3'b000;
    {trig_mode_i, aux_sel_i, width} = 13'h0000;
    {exposure_rows_i, cycle_rows_i, row_clocks_i} = {32'(E), 32'h0000_0064, 32'(R)};
    frame_rows_i = 16'(N);
    event_enable_i = 6'h0f;
    ev_seen = 6'h00;
    repeat (8) @(posedge clock_i);
    reset_i <= 1'b0;
    t_rolling();
    t_triggers();
    t_global_overrun();
    finish_test();
  end
  initial
  begin
    #200000;
    err_total++;
    finish_test();
  end
endmodule // etsl_core_tb
`default_nettype wire
